/* rtl/sug_gating.sv */
// Purpose: Supply undervoltage gating of channels and serial interface
// Assumes: Pins and commands are synchronous to sys_clk_in
//          Supply flags are independent levels, each may glitch
// Notes:   Supply flags come from analog comparators and are synchronised
//          Supply changes reach the outputs on the third edge
`timescale 1ns/1ns
`include "sug_consts.svh"

// Contract
// R01: Both supplies low: outputs off, serial blocked
// R02: Logic supply low: refuse serial, reset registers
// R03: Analog undervoltage disables channels, auto re-enable
// R04: Between thresholds, off channels may stay off
// R05: Between thresholds, on channels stay on
// R06: Analog at or below 3.0 V ignores control
// R07: Limp selectable unless logic supply also low
// R08: Logic supply low: channels only via limp
// R09: Healthy supplies: channels follow serial commands
// R10: Host limits serial clock to 1 MHz; the code does so only with vdd_lop and vs_below_op, gives 0 while serial is refused, and 5 MHz otherwise
// R11: Host sends nothing during logic undervoltage
// R12: Pin high with sleep pin low enters limp
// R13: Supply flags synchronised before any gating
module sug_gating #(
  parameter int                 NUM_CH  = `SUG_NUM_CHANNELS,
  parameter int                 NUM_PIN = `SUG_NUM_PINS,
  parameter logic [15:0]        PIN_MAP = `SUG_PIN_MAP_DEFAULT
) (
  // Clock and reset
  input  wire logic                  sys_clk_in,
  input  wire logic                  reset_n_in,
  // Supply monitor flags
  input  wire sug_pkg::sug_supply_t  supply_in,
  // Direct pins
  input  wire logic [1:0]            direct_input_pins_in,
  input  wire logic                  idle_pin_in,
  // Serial channel command
  input  wire sug_pkg::sug_cmd_t     cmd_in,
  // Channel drive and status
  output logic [7:0]                 chan_en_out,
  output logic [7:0]                 chan_reg_out,
  output sug_pkg::sug_status_t       status_out,
  output sug_pkg::sug_mode_t         mode_out,
  output logic [15:0]                sclk_max_khz_out
);

  import sug_pkg::*;

  sug_supply_t  sync1_ff;
  sug_supply_t  sync2_ff;
  sug_supply_t  sup;
  logic [7:0]   chan_reg_ff;
  logic [7:0]   nxt_chan_reg;
  logic [7:0]   chan_on_ff;
  logic [7:0]   nxt_chan_on;
  logic [NUM_PIN-1:0] pin_lvl;
  logic [7:0]   pin_drive;
  logic [7:0]   chan_req;
  logic [7:0]   on_mask;
  sug_status_t  status_ff;
  sug_status_t  nxt_status;
  sug_mode_t    mode_ff;
  sug_mode_t    nxt_mode;
  logic [15:0]  sclk_ff;
  logic [15:0]  nxt_sclk;
  logic         limp_req;
  logic         sleep_req;
  logic         limp_avail;
  logic         in_band;
  logic         ctrl_block;
  logic         cmd_ok;
  logic         any_pin;
  logic         slow_sclk;

  // Two-stage supply flag synchroniser
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      sync1_ff <= `SUG_SUPPLY_RESET;
      sync2_ff <= `SUG_SUPPLY_RESET;
    end
    else
    begin
      sync1_ff <= supply_in;          // [R13]
      sync2_ff <= sync1_ff;           // [R13]
    end
  end

  assign sup = sync2_ff;

  // Direct pin levels
  assign pin_lvl = direct_input_pins_in;

  // Default mapping of direct pins to channels
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++)
    begin : g_map
      assign pin_drive[c] = (pin_lvl[0] & PIN_MAP[c])
                          | (pin_lvl[1] & PIN_MAP[NUM_CH + c]);
    end
  endgenerate

  // Supply condition decode
  always_comb
  begin
    in_band    = sup.vs_below_op && !sup.vs_uv;                      // [R04] [R05]
    ctrl_block = sup.vs_uv || sup.vs_at_min;                         // [R03] [R06]
    limp_avail = !(sup.vdd_uv && sup.vs_at_min);                     // [R07]
    slow_sclk  = sup.vdd_lop && sup.vs_below_op;                     // [R10]
  end

  // Mode decode from pins
  always_comb
  begin
    any_pin   = |pin_lvl;
    limp_req  = !idle_pin_in && any_pin;                             // [R12]
    sleep_req = !idle_pin_in && !any_pin;
    if (limp_req)
      nxt_mode = SUG_MODE_LIMP;                                      // [R12]
    else if (sleep_req)
      nxt_mode = SUG_MODE_SLEEP;
    else
      nxt_mode = SUG_MODE_ACTIVE;
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      mode_ff <= SUG_MODE_SLEEP;
    else
      mode_ff <= nxt_mode;
  end

  // Serial channel register, write only in active mode with healthy logic supply
  always_comb
  begin
    cmd_ok = cmd_in.valid && !sup.vdd_uv                             // [R02] [R08]
          && !sup.vs_at_min && (mode_ff == SUG_MODE_ACTIVE);         // [R06] [R09]
    nxt_chan_reg = chan_reg_ff;
    if (sup.vdd_uv || mode_ff == SUG_MODE_SLEEP)
      nxt_chan_reg = `SUG_CHAN_RESET;                                // [R01] [R02]
    else if (cmd_ok)
      nxt_chan_reg = cmd_in.chan;                                    // [R09]
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      chan_reg_ff <= `SUG_CHAN_RESET;
    else
      chan_reg_ff <= nxt_chan_reg;
  end

  // Channel drive with undervoltage gating
  always_comb
  begin
    case (mode_ff)
      SUG_MODE_LIMP:
        chan_req = limp_avail ? pin_drive : '0;                      // [R07] [R08]
      SUG_MODE_ACTIVE:
        chan_req = sup.vdd_uv ? '0 : (chan_reg_ff | pin_drive);      // [R08] [R09]
      default:
        chan_req = '0;
    endcase
    // Off channels may not be switched on inside the band
    on_mask = in_band ? chan_on_ff : 8'hff;                          // [R04] [R05]
    if (ctrl_block)
      nxt_chan_on = '0;                                              // [R01] [R03] [R06]
    else
      nxt_chan_on = chan_req & on_mask;                              // [R03] [R05]
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      chan_on_ff <= `SUG_CHAN_RESET;
    else
      chan_on_ff <= nxt_chan_on;
  end

  // Serial interface gating and status
  always_comb
  begin
    nxt_status.spi_accept     = !sup.vdd_uv && (mode_ff != SUG_MODE_SLEEP); // [R01] [R02]
    nxt_status.spi_write_ok   = nxt_status.spi_accept && (mode_ff == SUG_MODE_ACTIVE);
    nxt_status.spi_regs_reset = sup.vdd_uv || (mode_ff == SUG_MODE_SLEEP);  // [R02]
    nxt_status.sclk_fast_ok   = !slow_sclk;                                 // [R10]
    nxt_status.limp_avail     = limp_avail;                                 // [R07]
    nxt_status.limp_active    = (mode_ff == SUG_MODE_LIMP) && limp_avail;
    nxt_status.sleep          = (mode_ff == SUG_MODE_SLEEP);
    if (!nxt_status.spi_accept)
      nxt_sclk = `SUG_SCLK_NONE_KHZ;                                        // [R11]
    else if (nxt_status.sclk_fast_ok)
      nxt_sclk = `SUG_SCLK_FAST_KHZ;
    else
      nxt_sclk = `SUG_SCLK_SLOW_KHZ;                                        // [R10]
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      status_ff <= `SUG_STATUS_RESET;
    else
      status_ff <= nxt_status;
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      sclk_ff <= `SUG_SCLK_NONE_KHZ;
    else
      sclk_ff <= nxt_sclk;
  end

  assign chan_en_out      = chan_on_ff;
  assign chan_reg_out     = chan_reg_ff;
  assign status_out       = status_ff;
  assign mode_out         = mode_ff;
  assign sclk_max_khz_out = sclk_ff;

endmodule

/* shared/sug_consts.svh */
// Purpose: Constants for the supply undervoltage gating block
// Assumes: Included by bare name
// Notes:   Definitions only
`ifndef SUG_CONSTS_SVH
`define SUG_CONSTS_SVH

// Channel and direct input pin counts
`define SUG_NUM_CHANNELS      8
`define SUG_NUM_PINS          2

// Synchroniser depth for supply flags
`define SUG_SYNC_STAGES       2

// Default input mapping, one byte per pin: pin0 to ch2, pin1 to ch3
`define SUG_PIN_MAP_DEFAULT   16'h0804

// Reset value of the channel control register
`define SUG_CHAN_RESET        8'h00

// Reset values of the supply synchroniser and the status word
`define SUG_SUPPLY_RESET      5'h00
`define SUG_STATUS_RESET      7'h00

// Serial clock ceilings in kHz
`define SUG_SCLK_SLOW_KHZ     16'h03e8
`define SUG_SCLK_FAST_KHZ     16'h1388
`define SUG_SCLK_NONE_KHZ     16'h0000

// Lowest analog supply for channel control, in millivolts
`define SUG_VS_MIN_MV         16'h0bb8

`endif

/* shared/sug_pkg.sv */
// Purpose: Types for the supply undervoltage gating block
// Assumes: Constants come from sug_consts.svh
// Notes:   Types only
package sug_pkg;

  // Raw supply monitor indications, all active high
  typedef struct packed {
    logic vs_at_min;     // Analog supply at or below 3.0 V
    logic vs_uv;         // Analog supply in undervoltage
    logic vs_below_op;   // Analog supply below its operating threshold
    logic vdd_uv;        // Logic supply in undervoltage
    logic vdd_lop;       // Logic supply at its low operating level
  } sug_supply_t;

  // Serial channel command from the serial front end
  typedef struct packed {
    logic       valid;
    logic [7:0] chan;
  } sug_cmd_t;

  // Gating status presented to the rest of the device
  typedef struct packed {
    logic spi_accept;
    logic spi_write_ok;
    logic spi_regs_reset;
    logic sclk_fast_ok;
    logic limp_avail;
    logic limp_active;
    logic sleep;
  } sug_status_t;

  typedef enum logic [1:0] {
    SUG_MODE_SLEEP,
    SUG_MODE_ACTIVE,
    SUG_MODE_LIMP
  } sug_mode_t;

endpackage

/* sim/sug_host_model.sv */
// Purpose: Serial host command and clock rate model
// Assumes: Requests come from tb at the falling edge
// Notes:   Host picks its serial clock from the supply flags
`timescale 1ns/1ns
`include "sug_consts.svh"
module sug_host_model (
  // Supply view and requests
  input  wire sug_pkg::sug_supply_t supply_in,
  input  wire logic                 req_in,
  input  wire logic [7:0]           chan_in,
  // Serial command and clock rate
  output sug_pkg::sug_cmd_t         cmd_out,
  output logic [15:0]               sclk_khz_out
);
  import sug_pkg::*;
  assign cmd_out = {req_in && !supply_in.vdd_uv, chan_in};
  assign sclk_khz_out = (supply_in.vdd_lop && supply_in.vs_below_op) ?
    `SUG_SCLK_SLOW_KHZ : `SUG_SCLK_FAST_KHZ;
endmodule

/* sim/sug_gating_sva.sv */
// Purpose: Port assertions for the supply gating block
// Assumes: Bound to sug_gating
// Notes:   Supply flags act three edges after they change
`timescale 1ns/1ns
module sug_gating_sva (
  // Clock and reset
  input wire logic                 sys_clk_in,
  input wire logic                 reset_n_in,
  // Inputs
  input wire sug_pkg::sug_supply_t supply_in,
  input wire logic [1:0]           direct_input_pins_in,
  input wire logic                 idle_pin_in,
  input wire sug_pkg::sug_cmd_t    cmd_in,
  // Outputs
  input wire logic [7:0]           chan_en_out,
  input wire logic [7:0]           chan_reg_out,
  input wire sug_pkg::sug_status_t status_out,
  input wire sug_pkg::sug_mode_t   mode_out,
  input wire logic [15:0]          sclk_max_khz_out
);
  import sug_pkg::*;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_cmd_ok;
    (!supply_in.vdd_uv && !supply_in.vs_at_min && idle_pin_in) [*3]
      ##0 (cmd_in.valid && mode_out == SUG_MODE_ACTIVE);
  endsequence
  a_both_uv_off: assert property (
    (supply_in.vs_uv && supply_in.vdd_uv) [*3] |=> chan_en_out == 8'h00
      && !status_out.spi_accept) else $error("Both supplies low, outputs live");
  a_vdd_uv_reset: assert property (
    supply_in.vdd_uv [*3] |=> !status_out.spi_accept && chan_reg_out == 8'h00
      && sclk_max_khz_out == 16'h0000) else $error("Logic supply low, serial live");
  a_vs_uv_off: assert property (supply_in.vs_uv [*3] |=> chan_en_out == 8'h00)
    else $error("Analog undervoltage, channel on");
  a_band_no_on: assert property (
    (supply_in.vs_below_op && !supply_in.vs_uv) [*4] |=>
      (chan_en_out & ~$past(chan_en_out)) == 8'h00) else $error("Channel on in band");
  a_min_ignore: assert property (supply_in.vs_at_min [*3] |=> chan_en_out == 8'h00)
    else $error("Channel on at minimum supply");
  a_limp_none: assert property (
    (supply_in.vdd_uv && supply_in.vs_at_min) [*3] |=> !status_out.limp_avail)
    else $error("Limp offered without logic supply");
  a_limp_entry: assert property (
    (|direct_input_pins_in && !idle_pin_in && status_out.limp_avail)
      |=> mode_out == SUG_MODE_LIMP) else $error("Limp not entered");
  a_cmd_apply: assert property (
    s_cmd_ok |=> chan_reg_out == $past(cmd_in.chan)) else $error("Command lost");
endmodule
bind sug_gating sug_gating_sva chk (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
  .supply_in(supply_in), .direct_input_pins_in(direct_input_pins_in),
  .idle_pin_in(idle_pin_in), .cmd_in(cmd_in), .chan_en_out(chan_en_out),
  .chan_reg_out(chan_reg_out), .status_out(status_out), .mode_out(mode_out),
  .sclk_max_khz_out(sclk_max_khz_out));

/* sim/tb.sv */
// Purpose: Self-checking bench for the supply gating block
// Assumes: Inputs change at the falling edge
// Notes:   Supply changes are given four cycles to land
`timescale 1ns/1ns
`include "sug_consts.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  import sug_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  sug_supply_t supply     = '0;
  logic [1:0]  pins       = 2'h0;
  logic        idle       = 1'b1;
  logic        req        = 1'b0;
  logic [7:0]  chan       = 8'h00;
  sug_cmd_t    cmd;
  logic [7:0]  chan_en, chan_reg;
  sug_status_t st;
  sug_mode_t   mode;
  logic [15:0] sclk_max, host_khz;
  int          fail_count = 0;
  int          checked    = 0;
  initial forever #50 sys_clk_in = ~sys_clk_in;
  sug_gating uut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .supply_in(supply),
    .direct_input_pins_in(pins), .idle_pin_in(idle), .cmd_in(cmd), .chan_en_out(chan_en),
    .chan_reg_out(chan_reg), .status_out(st), .mode_out(mode), .sclk_max_khz_out(sclk_max));
  sug_host_model host (.supply_in(supply), .req_in(req), .chan_in(chan), .cmd_out(cmd),
    .sclk_khz_out(host_khz));
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  task automatic send(input logic [7:0] c);
    chan = c;
    req = 1'b1;
    cyc(1);
    req = 1'b0;
    cyc(2);
  endtask
  task automatic t_reset;
    cyc(2);
    `CHK(mode, SUG_MODE_SLEEP)
    `CHK(chan_en, 8'h00)
    reset_n_in = 1'b1;
    cyc(4);
    $display("done reset");
  endtask
  task automatic t_cmd;
    chan = 8'ha5;
    req = 1'b1;
    cyc(1);
    `CHK(chan_reg, 8'ha5)
    chan = 8'h3c;
    cyc(1);
    req = 1'b0;
    `CHK(chan_en, 8'ha5)
    `CHK(chan_reg, 8'h3c)
    cyc(1);
    `CHK(chan_en, 8'h3c)
    `CHK(sclk_max, `SUG_SCLK_FAST_KHZ)
    `CHK(st.sclk_fast_ok, 1'b1)
    `CHK(st.spi_write_ok, 1'b1)
    $display("done cmd");
  endtask
  task automatic t_band;
    supply = 5'h04;
    cyc(4);
    `CHK(chan_en, 8'h3c)
    send(8'hff);
    `CHK(chan_en, 8'h3c)
    send(8'h0c);
    `CHK(chan_en, 8'h0c)
    supply = 5'h05;
    cyc(4);
    `CHK(sclk_max, `SUG_SCLK_SLOW_KHZ)
    `CHK(st.sclk_fast_ok, 1'b0)
    `CHK(host_khz <= sclk_max, 1'b1)
    supply = 5'h0c;
    cyc(4);
    `CHK(chan_en, 8'h00)
    supply = 5'h00;
    cyc(4);
    `CHK(chan_en, 8'h0c)
    $display("done band");
  endtask
  task automatic t_vdd;
    supply = 5'h02;
    cyc(1);
    `CHK(st.spi_accept, 1'b1)
    cyc(3);
    `CHK(st.spi_accept, 1'b0)
    `CHK(st.spi_regs_reset, 1'b1)
    `CHK(chan_reg, 8'h00)
    `CHK(sclk_max, `SUG_SCLK_NONE_KHZ)
    send(8'hff);
    `CHK(chan_en, 8'h00)
    idle = 1'b0;
    pins = 2'h1;
    cyc(3);
    `CHK(mode, SUG_MODE_LIMP)
    `CHK(chan_en, 8'h04)
    `CHK(st.limp_active, 1'b1)
    `CHK(st.spi_write_ok, 1'b0)
    $display("done vdd");
  endtask
  task automatic t_min;
    supply = 5'h10;
    cyc(4);
    `CHK(st.limp_avail, 1'b1)
    `CHK(chan_en, 8'h00)
    supply = 5'h1a;
    cyc(4);
    `CHK(st.limp_avail, 1'b0)
    `CHK(st.spi_regs_reset, 1'b1)
    `CHK(st.spi_accept, 1'b0)
    `CHK(chan_en, 8'h00)
    $display("done min");
  endtask
  task automatic t_sleep;
    supply = 5'h00;
    pins = 2'h0;
    cyc(4);
    `CHK(mode, SUG_MODE_SLEEP)
    `CHK(st.sleep, 1'b1)
    `CHK(st.spi_accept, 1'b0)
    `CHK(sclk_max, `SUG_SCLK_NONE_KHZ)
    send(8'hff);
    `CHK(chan_reg, 8'h00)
    `CHK(chan_en, 8'h00)
    pins = 2'h1;
    cyc(3);
    `CHK(mode, SUG_MODE_LIMP)
    `CHK(chan_en, 8'h04)
    `CHK(st.spi_accept, 1'b1)
    `CHK(st.spi_write_ok, 1'b0)
    send(8'hff);
    `CHK(chan_reg, 8'h00)
    pins = 2'h3;
    cyc(2);
    `CHK(chan_en, 8'h0c)
    idle = 1'b1;
    pins = 2'h0;
    cyc(2);
    `CHK(mode, SUG_MODE_ACTIVE)
    $display("done sleep");
  endtask
  task automatic wrap_up;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    t_reset;
    t_cmd;
    t_band;
    t_vdd;
    t_min;
    t_sleep;
    wrap_up;
  end
endmodule
